//--- hw/pwrsv_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - set gate bit stops that peripheral clock, freezes it, blocks its register access.
// - clearing gate bit restarts clock; module resumes its frozen state.
// - gating acts in active and idle; other sleep modes stop clocks anyway.
// - enabled converter stays on in sleep; re-enable gives extended conversion.
// - comparator off outside idle and noise sleep; reference kept if it uses it.
// - fuse-enabled brownout detector stays on in all sleep modes.
// - enabled watchdog keeps running in all sleep modes.
// - reference on only while brownout, comparator or converter needs it.
// - input buffers off when io and converter clocks both stop, except wake pins.
// - debug fuse keeps main clock running in every sleep mode.
// - registers decode at data offset; sleep and core also at offset minus 0x20 in io space.
// - mode field bits 3:1 select idle, noise, down, save, standby, extended.
// - sleep instruction sleeps only when sleep enable bit 0 is one.
// - global pull-up off bit 4 kills every pull-up, even 0b01 pins.
// - vector select bit 1 picks flash start or boot section start.
// - select change needs unlock bit first, then select write within four cycles.
// - interrupts masked from unlock until after next instruction, or four cycles.
// - hardware clears unlock four cycles after writing, or on select write.
// - boot lock bits block interrupts while running the other section.
// - gate register 0x64: two-wire 7, timers 6 5 3, spi 2, uart 1, adc 0.
// - interrupt wake holds core four cycles past start-up, then runs handler.
module pwrsv_top
(
  input wire logic clk,
  input wire logic srst,
  input wire pwrsv_pkg::pwrsv_bus_t bus,
  output logic [7:0] rdata,
  output logic [7:0] gateRdMask,
  input wire logic sleepInstr,
  input wire logic wakeIrq,
  input wire logic startupDone,
  input wire logic instrDone,
  input wire logic inBootSection,
  input wire logic appLockBit,
  input wire logic bootLockBit,
  input wire logic [15:0] bootStart,
  input wire logic [7:0] pinDirectionBit,
  input wire logic [7:0] pinOutputBit,
  input wire logic [7:0] wakePins,
  input wire pwrsv_pkg::pwrsv_analog_t analog,
  output logic [7:0] periphClkEn,
  output logic [7:0] pullupOn,
  output logic [7:0] inBufEn,
  output logic [15:0] vectorBase,
  output logic intBlock,
  output logic coreHalt,
  output logic asleep,
  output logic [2:0] sleepModeOut,
  output pwrsv_pkg::pwrsv_keep_t keep
);
  import pwrsv_pkg::*;

  // map io-space addresses onto data-space offsets
  function automatic logic [7:0] dataAddr(input logic io, input logic [7:0] a);
    dataAddr = io ? a + IO_BASE : a;
  endfunction

  logic [7:0] sleepCtl, next_sleepCtl;
  logic [7:0] coreCtl, next_coreCtl;
  logic [7:0] gate, next_gate;
  pwrsv_state_t state, next_state;
  logic [2:0] haltCnt, next_haltCnt;
  logic adcWasOn, next_adcWasOn;
  logic longConv, next_longConv;
  logic [7:0] addr;
  logic inRange;
  logic hitSleep, hitCore, hitGate;
  logic unlockWrite, selWrite, unlockActive, unlockMask;
  logic [2:0] mode;
  logic idleLike, clocksStopped;

  // io space only covers 0x00..0x3F
  assign inRange = !bus.ioSpace || bus.addr <= IO_TOP;
  assign addr = dataAddr(bus.ioSpace, bus.addr);
  always_comb
  begin
    hitSleep = 1'b0;
    hitCore = 1'b0;
    hitGate = 1'b0;
    if (inRange && addr == OFF_SLEEP)
      hitSleep = 1'b1;
    else if (inRange && addr == OFF_CORE)
      hitCore = 1'b1;
    else if (!bus.ioSpace && addr == OFF_GATE)
      hitGate = 1'b1;
  end

  assign unlockWrite = bus.wr && hitCore && bus.wdata[CORE_UNLOCK_BIT];
  assign selWrite = bus.wr && hitCore && !bus.wdata[CORE_UNLOCK_BIT];

  pwrsv_unlock u_unlock
  (
    .clk(clk),
    .srst(srst),
    .unlockWrite(unlockWrite),
    .selWrite(selWrite),
    .instrDone(instrDone),
    .unlockActive(unlockActive),
    .intMask(unlockMask)
  );

  // register writes; select only moves inside the unlock window
  always_comb
  begin
    next_sleepCtl = sleepCtl;
    next_coreCtl = coreCtl;
    next_gate = gate;
    if (bus.wr && hitSleep)
      next_sleepCtl = bus.wdata & SLEEP_MASK;
    if (bus.wr && hitGate)
      next_gate = bus.wdata & GATE_MASK;
    if (bus.wr && hitCore)
    begin
      next_coreCtl[CORE_PUOFF_BIT] = bus.wdata[CORE_PUOFF_BIT];
      if (selWrite && unlockActive)
        next_coreCtl[CORE_VSEL_BIT] = bus.wdata[CORE_VSEL_BIT];
    end
    // stored unlock copy stays clear; reads take the live window instead,
    // since a registered copy would trail the window by one cycle
    next_coreCtl[CORE_UNLOCK_BIT] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sleepCtl <= RST_SLEEP;
      coreCtl <= RST_CORE;
      gate <= RST_GATE;
    end
    else
    begin
      sleepCtl <= next_sleepCtl;
      coreCtl <= next_coreCtl;
      gate <= next_gate;
    end
  end

  // read data registered; unmapped reads zero
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (bus.rd && hitSleep)
      next_rdata = sleepCtl;
    else if (bus.rd && hitCore)
      next_rdata = {coreCtl[7:1], unlockActive};
    else if (bus.rd && hitGate)
      next_rdata = gate;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  // sleep sequencing
  assign mode = sleepCtl[SLP_MODE_LO +: 3];
  always_comb
  begin
    next_state = state;
    next_haltCnt = haltCnt;
    case (state)
      ST_RUN:
      begin
        // without enable the sleep instruction falls through
        if (sleepInstr && sleepCtl[SLP_EN_BIT])
          next_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wakeIrq && startupDone)
        begin
          next_state = ST_WAKE;
          next_haltCnt = WAKE_HALT_CYCLES;
        end
      end
      ST_WAKE:
      begin
        if (haltCnt == 3'h1)
          next_state = ST_RUN;
        next_haltCnt = haltCnt - 3'h1;
      end
      default:
        next_state = ST_RUN;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_RUN;
      haltCnt <= 3'h0;
    end
    else
    begin
      state <= next_state;
      haltCnt <= next_haltCnt;
    end
  end

  assign asleep = state == ST_SLEEP;
  assign coreHalt = state != ST_RUN;
  assign sleepModeOut = mode;
  assign idleLike = !asleep || mode == MODE_IDLE;
  // io and converter clocks both stop in every mode but idle and noise
  assign clocksStopped = asleep && mode != MODE_IDLE && mode != MODE_NOISE;

  // gate acts in active and idle; deeper modes stop the clocks anyway
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      periphClkEn[i] = idleLike && !gate[i] && GATE_MASK[i];
      gateRdMask[i] = GATE_MASK[i] && !gate[i];
      pullupOn[i] = !coreCtl[CORE_PUOFF_BIT] && !pinDirectionBit[i] && pinOutputBit[i];
      inBufEn[i] = !clocksStopped || wakePins[i];
    end
  end
  // frozen state is inside each peripheral; clock removal alone preserves it

  assign vectorBase = coreCtl[CORE_VSEL_BIT] ? bootStart : 16'h0000;
  assign intBlock = unlockMask
    || (coreCtl[CORE_VSEL_BIT] && appLockBit && !inBootSection)
    || (!coreCtl[CORE_VSEL_BIT] && bootLockBit && inBootSection);

  // converter off then on forces one long conversion
  always_comb
  begin
    next_adcWasOn = keep.adcOn;
    next_longConv = longConv;
    if (keep.adcOn && !adcWasOn)
      next_longConv = 1'b1;
    else if (keep.adcOn && instrDone)
      next_longConv = 1'b0; // approximation: first instruction after restart ends it
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      adcWasOn <= 1'b0;
      longConv <= 1'b1;
    end
    else
    begin
      adcWasOn <= next_adcWasOn;
      longConv <= next_longConv;
    end
  end

  assign keep.adcOn = analog.adcEnabled && !gate[G_ADC];
  assign keep.adcLongConv = longConv;
  assign keep.compOn = analog.compEnabled
    && (!asleep || mode == MODE_IDLE || mode == MODE_NOISE);
  assign keep.brownoutOn = analog.brownoutFuse;
  assign keep.watchdogOn = analog.watchdogEnabled;
  assign keep.refOn = analog.brownoutFuse || (analog.compEnabled && analog.compUsesRef)
    || keep.adcOn;
  assign keep.mainClkOn = !asleep || analog.debugFuse || mode == MODE_STBY
    || mode == MODE_XSTBY || mode == MODE_IDLE || mode == MODE_NOISE;
  assign keep.inBufOn = !clocksStopped;

  a_sleep_needs_en: assert property (@(posedge clk) disable iff (srst)
    (state == ST_RUN && sleepInstr && !sleepCtl[SLP_EN_BIT]) |=> state == ST_RUN)
    else $error("sleep entered without enable");
  a_sleep_enters: assert property (@(posedge clk) disable iff (srst)
    (state == ST_RUN && sleepInstr && sleepCtl[SLP_EN_BIT]) |=> asleep)
    else $error("sleep not entered");
  sequence s_wake;
    asleep && wakeIrq && startupDone;
  endsequence
  a_wake_halt: assert property (@(posedge clk) disable iff (srst)
    s_wake |=> coreHalt [*4] ##1 !coreHalt)
    else $error("wake halt not four cycles");
  a_sel_locked: assert property (@(posedge clk) disable iff (srst)
    (selWrite && !unlockActive) |=> $stable(coreCtl[CORE_VSEL_BIT]))
    else $error("select changed without unlock");
  a_gate_stops: assert property (@(posedge clk) disable iff (srst)
    gate[G_TIM0] |-> !periphClkEn[G_TIM0])
    else $error("gated clock running");
  a_pullup_off: assert property (@(posedge clk) disable iff (srst)
    coreCtl[CORE_PUOFF_BIT] |-> pullupOn == 8'h00)
    else $error("pull-up on while disabled");
  a_comp_sleep: assert property (@(posedge clk) disable iff (srst)
    (asleep && mode == MODE_PDOWN) |-> !keep.compOn)
    else $error("comparator on in deep sleep");
  a_ref_needed: assert property (@(posedge clk) disable iff (srst)
    keep.refOn |-> (analog.brownoutFuse || analog.compUsesRef || keep.adcOn))
    else $error("reference on without user");
  a_conv_restart: assert property (@(posedge clk) disable iff (srst)
    (keep.adcOn && !adcWasOn) |=> keep.adcLongConv)
    else $error("no long conversion after converter restart");
  a_block_boot: assert property (@(posedge clk) disable iff (srst)
    (!coreCtl[CORE_VSEL_BIT] && bootLockBit && inBootSection) |-> intBlock)
    else $error("interrupt open in locked boot code");
  a_deep_gate: assert property (@(posedge clk) disable iff (srst)
    (asleep && mode != MODE_IDLE) |-> periphClkEn == 8'h00)
    else $error("peripheral clock running in deep sleep");
endmodule
`default_nettype wire

//--- hw/pwrsv_pkg.sv
`default_nettype none
package pwrsv_pkg;
  // data-space offsets; io-space is offset minus the io base
  localparam logic [7:0] IO_BASE = 8'h20;
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] OFF_SLEEP = 8'h53;
  localparam logic [7:0] OFF_CORE = 8'h55;
  localparam logic [7:0] OFF_GATE = 8'h64;
  localparam logic [7:0] RST_SLEEP = 8'h00;
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_GATE = 8'h00;
  // field positions
  localparam int SLP_EN_BIT = 0;
  localparam int SLP_MODE_LO = 1;
  localparam int CORE_UNLOCK_BIT = 0;
  localparam int CORE_VSEL_BIT = 1;
  localparam int CORE_PUOFF_BIT = 4;
  localparam logic [7:0] GATE_MASK = 8'hEF;
  localparam logic [7:0] SLEEP_MASK = 8'h0F;
  localparam logic [7:0] CORE_MASK = 8'h13;
  // gate bit positions
  localparam int G_ADC = 0;
  localparam int G_UART = 1;
  localparam int G_SPI = 2;
  localparam int G_TIM1 = 3;
  localparam int G_TIM0 = 5;
  localparam int G_TIM2 = 6;
  localparam int G_TWI = 7;
  // timing counts in cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_NOISE = 3'b001,
    MODE_PDOWN = 3'b010,
    MODE_PSAVE = 3'b011,
    MODE_RSV4 = 3'b100,
    MODE_RSV5 = 3'b101,
    MODE_STBY = 3'b110,
    MODE_XSTBY = 3'b111
  } pwrsv_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } pwrsv_state_t;

  // register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic ioSpace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwrsv_bus_t;

  // analog and support block needs
  typedef struct packed {
    logic adcEnabled;
    logic compEnabled;
    logic compUsesRef;
    logic brownoutFuse;
    logic watchdogEnabled;
    logic debugFuse;
  } pwrsv_analog_t;

  typedef struct packed {
    logic adcOn;
    logic adcLongConv;
    logic compOn;
    logic refOn;
    logic brownoutOn;
    logic watchdogOn;
    logic mainClkOn;
    logic inBufOn;
  } pwrsv_keep_t;
endpackage
`default_nettype wire

//--- hw/pwrsv_unlock.sv
`timescale 1ns/1ps
`default_nettype none
// timed unlock window for the vector select bit
module pwrsv_unlock
(
  input wire logic clk,
  input wire logic srst,
  input wire logic unlockWrite,
  input wire logic selWrite,
  input wire logic instrDone,
  output logic unlockActive,
  output logic intMask
);
  import pwrsv_pkg::*;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic tail;
  logic next_tail;

  // count down the window; a select write closes it early
  always_comb
  begin
    next_cnt = cnt;
    next_tail = tail;
    if (unlockWrite)
    begin
      next_cnt = UNLOCK_CYCLES;
      next_tail = 1'b0;
    end
    else if (selWrite && cnt != 3'h0)
    begin
      next_cnt = 3'h0;
      next_tail = 1'b1; // mask until next instruction ends
    end
    else if (cnt != 3'h0)
    begin
      next_cnt = cnt - 3'h1;
    end
    else if (tail && instrDone)
    begin
      next_tail = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt <= 3'h0;
      tail <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tail <= next_tail;
    end
  end

  assign unlockActive = cnt != 3'h0;
  // masking starts in the very cycle the unlock bit is written
  assign intMask = unlockWrite || unlockActive || tail;

  // window is live for the four cycles after the write and closed on the fifth
  a_unlock_expires: assert property (@(posedge clk) disable iff (srst)
    (unlockWrite && !selWrite) ##1 (!selWrite && !unlockWrite) [*4] |=> !unlockActive)
    else $error("unlock window outlived four cycles");
  a_unlock_masks: assert property (@(posedge clk) disable iff (srst)
    unlockWrite |-> intMask ##1 intMask)
    else $error("interrupts not masked after unlock");
endmodule
`default_nettype wire

//--- sim/pwrsv_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pwrsv_top_tb;
  import pwrsv_pkg::*;
  // stimulus, all driven from time zero
  logic clk = 1'b0;
  logic srst = 1'b1;
  pwrsv_bus_t bus = '0;
  logic sleepInstr = 1'b0;
  logic wakeIrq = 1'b0;
  logic startupDone = 1'b0;
  logic instrDone = 1'b0;
  logic inBootSection = 1'b0;
  logic appLockBit = 1'b0;
  logic bootLockBit = 1'b0;
  logic [15:0] bootStart = 16'h1C00;
  logic [7:0] pinDirectionBit = 8'h0F;
  logic [7:0] pinOutputBit = 8'h33;
  logic [7:0] wakePins = 8'h0F;
  pwrsv_analog_t analog = '0;
  logic [7:0] rdata, gateRdMask, periphClkEn, pullupOn, inBufEn;
  logic [15:0] vectorBase;
  logic intBlock, coreHalt, asleep;
  logic [2:0] sleepModeOut;
  pwrsv_keep_t keep;
  int errors = 0;
  int nChecks = 0;

  // 40 MHz
  always #12.5 clk = ~clk;

  pwrsv_top DUT (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .gateRdMask(gateRdMask),
    .sleepInstr(sleepInstr), .wakeIrq(wakeIrq), .startupDone(startupDone),
    .instrDone(instrDone), .inBootSection(inBootSection), .appLockBit(appLockBit),
    .bootLockBit(bootLockBit), .bootStart(bootStart), .pinDirectionBit(pinDirectionBit),
    .pinOutputBit(pinOutputBit), .wakePins(wakePins), .analog(analog),
    .periphClkEn(periphClkEn), .pullupOn(pullupOn), .inBufEn(inBufEn),
    .vectorBase(vectorBase), .intBlock(intBlock), .coreHalt(coreHalt), .asleep(asleep),
    .sleepModeOut(sleepModeOut), .keep(keep));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, ioSpace: io, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // data is registered at the edge that takes the strobe, so look just after that edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, ioSpace: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic pulse_sleep;
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    rchk(OFF_SLEEP, RST_SLEEP, "sleep reset");
    rchk(OFF_CORE, RST_CORE, "core reset");
    rchk(OFF_GATE, RST_GATE, "gate reset");
    rchk(8'h54, 8'h00, "unmapped read");
    chk("vector base flash", 16'h0000, vectorBase);
    $display("test reset done");
  endtask

  task automatic t_gate;
    wr(1'b0, OFF_GATE, 8'hFF); // peripherals left disabled before gating
    chk("all gated clk", 16'h0000, {8'h00, periphClkEn & GATE_MASK});
    chk("all gated access", 16'h0000, {8'h00, gateRdMask});
    rchk(OFF_GATE, GATE_MASK, "gate readback");
    // each bit stops exactly its own peripheral
    for (int i = 0; i < 8; i++)
      if (GATE_MASK[i])
      begin
        wr(1'b0, OFF_GATE, 8'h01 << i);
        chk("one gated", {8'h00, GATE_MASK & ~(8'h01 << i)}, {8'h00, periphClkEn & GATE_MASK});
      end
    wr(1'b0, OFF_GATE, 8'h00);
    chk("ungated clk", {8'h00, GATE_MASK}, {8'h00, periphClkEn & GATE_MASK});
    chk("ungated access", {8'h00, GATE_MASK}, {8'h00, gateRdMask});
    $display("test gate done");
  endtask

  task automatic t_io_pull;
    wr(1'b1, 8'h33, 8'h0C);
    rchk(OFF_SLEEP, 8'h0C, "io sleep");
    wr(1'b1, 8'h44, 8'h01);
    rchk(OFF_GATE, 8'h00, "io out of range");
    wr(1'b1, 8'h35, 8'h10);
    chk("pullups off", 16'h0000, {8'h00, pullupOn});
    rchk(OFF_CORE, 8'h10, "io core");
    wr(1'b0, OFF_CORE, 8'h00);
    chk("pullups on", 16'h0030, {8'h00, pullupOn});
    wr(1'b0, OFF_SLEEP, 8'h00);
    $display("test io and pullup done");
  endtask

  // enter one mode with every support block enabled, then wake by interrupt
  task automatic t_sleep(input logic [2:0] m, input logic [7:0] expBuf, input logic expComp);
    int n;
    n = 0;
    wr(1'b0, OFF_SLEEP, {4'h0, m, 1'b1});
    pulse_sleep();
    chk("asleep", 16'h0001, {15'h0, asleep});
    chk("mode", {13'h0, m}, {13'h0, sleepModeOut});
    // gating only matters in idle; deeper modes have every module clock stopped
    chk("peripheral clocks", {8'h00, (m == 3'b000) ? GATE_MASK : 8'h00},
      {8'h00, periphClkEn & GATE_MASK});
    chk("input buffers", {8'h00, expBuf}, {8'h00, inBufEn});
    chk("comparator", {15'h0, expComp}, {15'h0, keep.compOn});
    chk("converter", 16'h0001, {15'h0, keep.adcOn});
    chk("brownout", 16'h0001, {15'h0, keep.brownoutOn});
    chk("watchdog", 16'h0001, {15'h0, keep.watchdogOn});
    chk("main clock", 16'h0001, {15'h0, keep.mainClkOn});
    chk("reference", 16'h0001, {15'h0, keep.refOn});
    @(posedge clk);
    wakeIrq <= 1'b1;
    startupDone <= 1'b1;
    // bounded wait for the core to run again, counting halted awake cycles
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk);
      #1;
      if (coreHalt && !asleep)
        n++;
      if (!coreHalt)
        break;
      if (k == 39)
      begin
        errors++;
        test_done();
      end
    end
    chk("wake halt cycles", 16'h0004, n[15:0]);
    @(posedge clk);
    wakeIrq <= 1'b0;
    startupDone <= 1'b0;
    wr(1'b0, OFF_SLEEP, {4'h0, m, 1'b0});
    $display("test sleep mode %b done", m);
  endtask

  task automatic t_nosleep;
    wr(1'b0, OFF_SLEEP, 8'h04);
    pulse_sleep();
    chk("no sleep", 16'h0000, {14'h0, asleep, coreHalt});
    repeat (3) @(posedge clk);
    #1;
    chk("still running", 16'h0000, {14'h0, asleep, coreHalt});
    $display("test sleep disabled done");
  endtask

  task automatic t_vector;
    wr(1'b0, OFF_CORE, 8'h01);
    chk("mask on unlock", 16'h0001, {15'h0, intBlock});
    wr(1'b0, OFF_CORE, 8'h02);
    chk("boot vectors", bootStart, vectorBase);
    chk("mask held", 16'h0001, {15'h0, intBlock});
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
    @(posedge clk);
    #1;
    chk("mask released", 16'h0000, {15'h0, intBlock});
    rchk(OFF_CORE, 8'h02, "unlock cleared by select");
    // boot vectors with the application lock block the application side only
    @(posedge clk);
    appLockBit <= 1'b1;
    @(posedge clk);
    #1;
    chk("app blocked", 16'h0001, {15'h0, intBlock});
    @(posedge clk);
    inBootSection <= 1'b1;
    @(posedge clk);
    #1;
    chk("boot open", 16'h0000, {15'h0, intBlock});
    @(posedge clk);
    appLockBit <= 1'b0;
    inBootSection <= 1'b0;
    // unlock left to expire, then a late select write must be ignored
    wr(1'b0, OFF_CORE, 8'h03);
    rchk(OFF_CORE, 8'h03, "unlock live");
    // this read lands on the fifth cycle after the unlock write
    @(posedge clk);
    rchk(OFF_CORE, 8'h02, "unlock expired");
    chk("mask expired", 16'h0000, {15'h0, intBlock});
    wr(1'b0, OFF_CORE, 8'h00);
    chk("late select ignored", bootStart, vectorBase);
    $display("test vector done");
  endtask

  // converter off and on again asks for one long conversion
  task automatic t_convert;
    chk("conv short", 16'h0000, {15'h0, keep.adcLongConv});
    wr(1'b0, OFF_GATE, 8'h01);
    chk("conv gated", 16'h0000, {15'h0, keep.adcOn});
    wr(1'b0, OFF_GATE, 8'h00);
    @(posedge clk);
    #1;
    chk("conv long", 16'h0001, {15'h0, keep.adcLongConv});
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
    #1;
    chk("conv done", 16'h0000, {15'h0, keep.adcLongConv});
    $display("test converter done");
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_gate();
    t_io_pull();
    @(posedge clk);
    analog <= '{adcEnabled: 1'b1, compEnabled: 1'b1, compUsesRef: 1'b0, brownoutFuse: 1'b1,
      watchdogEnabled: 1'b1, debugFuse: 1'b1};
    t_sleep(3'b000, 8'hFF, 1'b1);
    t_sleep(3'b001, 8'hFF, 1'b1);
    t_sleep(3'b010, 8'h0F, 1'b0);
    t_sleep(3'b011, 8'h0F, 1'b0);
    t_sleep(3'b110, 8'h0F, 1'b0);
    t_sleep(3'b111, 8'h0F, 1'b0);
    t_nosleep();
    t_vector();
    t_convert();
    test_done();
  end
endmodule
`default_nettype wire
